//--- bench/reset_line_model.sv
// Shared reset line: pull-up, device drain and outside pull-down
`timescale 1ns/1ps
module reset_line_model (
  // Device side
  input  wire reset_pin_out,
  input  wire reset_pin_oe,
  // Outside circuitry
  input  wire ext_low,
  // Resolved line
  output wire line
);
  // Pull-up wins only when nobody pulls low, so no stale level lingers
  assign line = ((reset_pin_oe && !reset_pin_out) || ext_low) ? 1'h0 : 1'h1;
endmodule

//--- bench/rsm_checker_assertions.sv
// Port-level checker of the reset sequence manager
`timescale 1ns/1ps
module rsm_checker #(
  parameter STAB_CYCLES   = 16,
  parameter OUT_WIDTH     = 4,
  parameter GLITCH_CYCLES = 4
) (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // Pin, supply and watchdog
  input wire        reset_pin_in,
  input wire        reset_pin_out,
  input wire        reset_pin_oe,
  input wire [2:0]  above_falling_threshold,
  input wire [1:0]  threshold_select,
  input wire        watchdog_underflow,
  // Core side
  input wire        core_reset_n,
  input wire        vector_fetch,
  input wire [15:0] vector_addr
);
  int oe_cnt;
  int quiet_cnt;
  int low_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------
  // Run lengths: pin drive, quiet wait with line high, low supply
  // ------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_cnt    <= 0;
      quiet_cnt <= 0;
      low_cnt   <= 0;
    end else begin
      oe_cnt    <= reset_pin_oe ? oe_cnt + 1 : 0;
      quiet_cnt <= (reset_pin_in && !reset_pin_oe && !core_reset_n && !vector_fetch) ?
                   quiet_cnt + 1 : 0;
      low_cnt   <= above_falling_threshold[threshold_select] ? 0 : low_cnt + 1;
    end
  end
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  pin_never_high_a: assert property (!reset_pin_out)
    else $error("reset pin driven high");
  fetch_seq_a: assert property ($rose(vector_fetch) |-> vector_addr == 16'hfffe
    ##1 vector_fetch && vector_addr == 16'hffff ##1 !vector_fetch)
    else $error("vector fetch not two cycles at fffe then ffff");
  release_sync_a: assert property ($rose(core_reset_n) |->
    $past(vector_fetch) || $past(vector_fetch, 2))
    else $error("core released without vector fetch");
  stab_delay_a: assert property ($rose(vector_fetch) |->
    quiet_cnt >= STAB_CYCLES && quiet_cnt <= STAB_CYCLES + 5)
    else $error("stabilisation delay length wrong");
  pin_width_a: assert property ($fell(reset_pin_oe) |-> oe_cnt >= OUT_WIDTH)
    else $error("reset pin released too early");
  pin_core_a: assert property (reset_pin_oe |-> !core_reset_n)
    else $error("core runs while pin driven");
  wdg_pin_a: assert property ($rose(watchdog_underflow) |-> ##[1:6] reset_pin_oe)
    else $error("watchdog did not drive pin");
  ext_pin_a: assert property ($fell(reset_pin_in) && !reset_pin_oe |->
    ##[1:6] reset_pin_oe)
    else $error("external pulse not answered");
  supply_hold_a: assert property (low_cnt > GLITCH_CYCLES + 8 |->
    reset_pin_oe && !core_reset_n)
    else $error("low supply not holding reset");
  // Main scenarios
  cover property ($rose(vector_fetch));
  cover property ($rose(watchdog_underflow));
  cover property ($fell(reset_pin_in) && !reset_pin_oe);
endmodule

bind reset_sequence_manager rsm_checker #(
  .STAB_CYCLES(STAB_CYCLES), .OUT_WIDTH(OUT_WIDTH), .GLITCH_CYCLES(GLITCH_CYCLES)
) checker_i (
  .pclk, .presetn, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
  .above_falling_threshold, .threshold_select, .watchdog_underflow,
  .core_reset_n, .vector_fetch, .vector_addr
);

//--- bench/tb_reset_sequence_manager.sv
// Self-checking bench of the reset sequence manager
`timescale 1ns/1ps
`include "reset_sequence_manager_map.vh"
module tb_reset_sequence_manager;
  // Shortened counts keep the run brief
  localparam STAB = 16;
  localparam OUTW = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        reset_pin_in, reset_pin_out, reset_pin_oe, ext_low, watchdog_underflow;
  logic        core_reset_n, vector_fetch, oscillator_enable, irq;
  logic [2:0]  above_rising_threshold, above_falling_threshold;
  logic [2:0]  clock_source_select, clock_source;
  logic [1:0]  threshold_select;
  logic [15:0] vector_addr;
  int          miscompares, total_checks;

  reset_sequence_manager #(.STAB_CYCLES(STAB), .OUT_WIDTH(OUTW), .GLITCH_CYCLES(4)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .above_rising_threshold,
    .above_falling_threshold, .watchdog_underflow, .threshold_select,
    .clock_source_select, .core_reset_n, .vector_fetch, .vector_addr, .clock_source,
    .oscillator_enable, .irq);
  reset_line_model line_i (.reset_pin_out, .reset_pin_oe, .ext_low, .line(reset_pin_in));

  // ------------------------------------------------
  // Clock, compare, bus and stimulus tasks
  // ------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until pready is sampled high, for at most 16 cycles
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    chk(pready, 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  // Bounded waits: first for the core to enter reset, then to leave it
  task settle;
    int n;
    n = 0;
    while (core_reset_n !== 1'h0 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk(core_reset_n, 1'h0);
    n = 0;
    while (core_reset_n !== 1'h1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(core_reset_n, 1'h1);
  endtask
  task ext_pulse(input int len);
    @(posedge pclk) ext_low <= 1'h1;
    repeat (len) @(posedge pclk);
    ext_low <= 1'h0;
  endtask
  task supply(input logic [2:0] r, input logic [2:0] f);
    @(posedge pclk);
    above_rising_threshold  <= r;
    above_falling_threshold <= f;
  endtask
  task results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, ext_low, watchdog_underflow} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    above_rising_threshold = 3'h7;
    above_falling_threshold = 3'h7;
    threshold_select = 2'h0;
    clock_source_select = 3'h5;
    repeat (10) @(posedge pclk);
    chk({reset_pin_oe, core_reset_n}, 2'h2);
    presetn <= 1'h1;
    settle();
    chk({clock_source, oscillator_enable}, {3'h5, 1'h1});
    rdchk(`RSM_FLAGS_OFFSET, 32'h10);
    apb(1'h1, `RSM_FLAGS_OFFSET, 32'h0);
    rdchk(`RSM_FLAGS_OFFSET, 32'h0);
    apb(1'h1, `RSM_STATUS_OFFSET, 32'hf);
    rdchk(12'h010, 32'h0);
    chk(err, 1'h1);
    // Watchdog underflow, then its event seen through the mask
    @(posedge pclk) watchdog_underflow <= 1'h1;
    repeat (2) @(posedge pclk);
    watchdog_underflow <= 1'h0;
    settle();
    rdchk(`RSM_FLAGS_OFFSET, 32'h01);
    chk(irq, 1'h0);
    apb(1'h1, `RSM_MASK_OFFSET, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'h1);
    apb(1'h1, `RSM_STATUS_OFFSET, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'h0);
    // Supply loss, then recovery only above the upper threshold
    supply(3'h0, 3'h0);
    repeat (20) @(posedge pclk);
    chk({reset_pin_oe, core_reset_n, reset_pin_in}, 3'h4);
    supply(3'h0, 3'h7);
    repeat (20) @(posedge pclk);
    chk(core_reset_n, 1'h0);
    supply(3'h7, 3'h7);
    settle();
    rdchk(`RSM_FLAGS_OFFSET, 32'h10);
    // Short and long outside pulses leave the supply flag alone
    ext_pulse(3);
    settle();
    ext_pulse(40);
    settle();
    rdchk(`RSM_FLAGS_OFFSET, 32'h10);
    // Between thresholds on the way down, and a brief dip
    supply(3'h0, 3'h7);
    repeat (20) @(posedge pclk);
    chk(core_reset_n, 1'h1);
    supply(3'h0, 3'h0);
    @(posedge pclk);
    supply(3'h0, 3'h7);
    repeat (20) @(posedge pclk);
    chk(core_reset_n, 1'h1);
    supply(3'h7, 3'h7);
    // Each option level watches its own comparator
    for (int s = 0; s < 3; s++) begin
      @(posedge pclk) threshold_select <= s[1:0];
      supply(~(3'h1 << s), ~(3'h1 << s));
      repeat (20) @(posedge pclk);
      chk(reset_pin_oe, 1'h1);
      supply(3'h7, 3'h7);
      settle();
    end
    results();
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results();
  end
endmodule

//--- core/reset_sequence_manager.v
// Reset sequence manager: reset sources, pin driver, phase sequencer and flags
//
// Summary of operation
// RQ1 - Hold reset while supply below threshold
// RQ2 - Rising threshold going up, falling going down
// RQ3 - Drive reset pin low during supply reset
// RQ4 - Supply flag set by hardware, cleared writing zero
// RQ5 - Three threshold levels chosen by option input
// RQ6 - All sources drive pin, low through delay
// RQ7 - Phases: source delay, 4096 cycles, fetch
// RQ8 - Vector fetch two cycles at FFFE-FFFF
// RQ9 - External reset caught without running clock
// RQ10 - Outside holds pin low minimum input width
// RQ11 - Pin driven low minimum output width
// RQ12 - Watchdog underflow drives pin, starts sequence
// RQ13 - Pin open drain, never driven high
// RQ14 - Short supply spikes filtered out
// RQ15 - Clock source chosen by option
// RQ16 - Resonator keeps running during reset
// RQ17 - Supply flag survives later resets
// RQ18 - Watchdog flag set, cleared by zero or supply
// RQ19 - Assert asynchronously, release synchronously; core_reset_n drops on a clock edge after a source event here
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "reset_sequence_manager_map.vh"

module reset_sequence_manager #(
  parameter STAB_CYCLES    = `STAB_CYCLES,
  parameter OUT_WIDTH      = `MIN_OUT_WIDTH_CYCLES,
  parameter GLITCH_CYCLES  = `SUPPLY_GLITCH_CYCLES
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Reset pin, open drain
  input  wire        reset_pin_in,
  output reg         reset_pin_out,
  output reg         reset_pin_oe,
  // Analog supply comparators
  input  wire [2:0]  above_rising_threshold,
  input  wire [2:0]  above_falling_threshold,
  // Watchdog
  input  wire        watchdog_underflow,
  // Option byte (static)
  input  wire [1:0]  threshold_select,
  input  wire [2:0]  clock_source_select,
  // Core side
  output reg         core_reset_n,
  output reg         vector_fetch,
  output reg  [15:0] vector_addr,
  output reg  [2:0]  clock_source,
  output reg         oscillator_enable,
  output reg         irq
);

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  localparam [1:0] ST_DELAY = 2'd0;
  localparam [1:0] ST_STAB  = 2'd1;
  localparam [1:0] ST_FETCH = 2'd2;
  localparam [1:0] ST_RUN   = 2'd3;

  localparam [1:0] SEL_LOW  = 2'd0;
  localparam [1:0] SEL_MID  = 2'd1;
  localparam [1:0] SEL_HIGH = 2'd2;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [1:0]  pin_sync;
  reg         ext_async;
  reg         ext_seen;
  reg  [1:0]  ext_sync;
  reg  [2:0]  rise_sync_a;
  reg  [2:0]  rise_sync;
  reg  [2:0]  fall_sync_a;
  reg  [2:0]  fall_sync;
  reg  [1:0]  wdg_sync;
  reg         supply_low;
  reg         supply_filtered;
  reg  [15:0] glitch_count;
  reg  [1:0]  state;
  reg  [15:0] count;
  reg  [15:0] width_count;
  reg         wdg_prev;
  reg         wdg_cause;
  reg  [`EV_WIDTH-1:0] status;
  reg  [`EV_WIDTH-1:0] mask;
  reg         supply_reset_flag;
  reg         watchdog_reset_flag;
  reg         supply_prev;
  reg         ext_prev;
  wire        rise_ok;
  wire        fall_ok;
  wire        wdg_event;
  wire        supply_event;
  wire        ext_event;
  wire        release_event;
  wire        apb_write;
  wire        apb_read;
  wire [`EV_WIDTH-1:0] events;

  // Pick one comparator of three by option
  function level_of;
    input [2:0] lines;
    input [1:0] sel;
    begin
      case (sel)
        SEL_LOW:  level_of = lines[0];
        SEL_MID:  level_of = lines[1];
        SEL_HIGH: level_of = lines[2];
        default:  level_of = lines[0];
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Asynchronous external reset capture
  // --------------------------------------------------------------------------
  // Catches a pin low even with the clock stopped; cleared once seen in domain
  // The device's own drive also lands here; it stretches the low phase and sets the external event bit
  always @(negedge reset_pin_in or posedge ext_seen) begin
    if (ext_seen)
      ext_async <= 1'b0;
    else
      ext_async <= 1'b1; // RQ9
  end

  // Only the second stage of each synchroniser is read by logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync    <= 2'b11;
      ext_sync    <= 2'b00;
      rise_sync_a <= 3'b000;
      rise_sync   <= 3'b000;
      fall_sync_a <= 3'b000;
      fall_sync   <= 3'b000;
      wdg_sync    <= 2'b00;
    end else begin
      pin_sync    <= {pin_sync[0], reset_pin_in};
      ext_sync    <= {ext_sync[0], ext_async};
      rise_sync_a <= above_rising_threshold;
      rise_sync   <= rise_sync_a;
      fall_sync_a <= above_falling_threshold;
      fall_sync   <= fall_sync_a;
      wdg_sync    <= {wdg_sync[0], watchdog_underflow};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ext_seen <= 1'b0;
    else
      ext_seen <= ext_sync[1] & ~ext_seen;
  end

  // --------------------------------------------------------------------------
  // Supply supervisor with hysteresis and spike filter
  // --------------------------------------------------------------------------
  assign rise_ok = level_of(rise_sync, threshold_select); // RQ5
  assign fall_ok = level_of(fall_sync, threshold_select);

  // Raw drop: while held in supply reset watch the rising level, otherwise the falling one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_low <= 1'b1;
    end else if (supply_filtered) begin
      supply_low <= ~rise_ok; // RQ2
    end else begin
      supply_low <= ~fall_ok; // RQ2
    end
  end

  // A drop must persist more than GLITCH_CYCLES before it resets; recovery is immediate.
  // Filtering ahead of the hysteresis keeps a short dip from latching the
  // rising threshold, which would otherwise turn a spike into a full reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glitch_count    <= 16'h0000;
      supply_filtered <= 1'b1;
    end else if (!supply_low) begin
      glitch_count    <= 16'h0000;
      supply_filtered <= 1'b0;
    end else if (glitch_count >= GLITCH_CYCLES[15:0]) begin
      supply_filtered <= 1'b1; // RQ14
    end else begin
      glitch_count    <= glitch_count + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Source events
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_prev    <= 1'b0;
      supply_prev <= 1'b1;
      ext_prev    <= 1'b0;
    end else begin
      wdg_prev    <= wdg_sync[1];
      supply_prev <= supply_filtered;
      ext_prev    <= ext_sync[1];
    end
  end

  assign wdg_event     = wdg_sync[1] & ~wdg_prev;
  assign supply_event  = supply_filtered & ~supply_prev;
  assign ext_event     = ext_sync[1] & ~ext_prev;
  assign release_event = (state == ST_FETCH) && (count == 16'h0001);

  // --------------------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------------------
  // Any source restarts at the delay phase; supply low pins it there
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_DELAY;
      count       <= 16'h0000;
      width_count <= 16'h0000;
    end else if (supply_filtered) begin
      state       <= ST_DELAY; // RQ1
      width_count <= 16'h0000;
    end else if (ext_event || wdg_event) begin
      state       <= ST_DELAY; // RQ12
      width_count <= 16'h0000;
    end else begin
      case (state)
        ST_DELAY: begin
          // Delay phase ends only after minimum width and when line is back high
          if (width_count < OUT_WIDTH[15:0]) begin
            width_count <= width_count + 16'h0001; // RQ11
          end else if (pin_sync[1]) begin
            state <= ST_STAB; // RQ7
            count <= 16'h0000;
          end
        end
        ST_STAB: begin
          if (count == STAB_CYCLES[15:0] - 16'h0001) begin
            state <= ST_FETCH; // RQ7
            count <= 16'h0000;
          end else begin
            count <= count + 16'h0001;
          end
        end
        ST_FETCH: begin
          if (count == `FETCH_CYCLES - 1) begin
            state <= ST_RUN; // RQ8
          end else begin
            count <= count + 16'h0001;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_DELAY;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Outputs to pin and core
  // --------------------------------------------------------------------------
  // Core reset drops on the clock edge after a source event, rises on a clock edge
  // Drive stops once the width is served; holding it would hide the line level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_out     <= 1'b0;
      reset_pin_oe      <= 1'b1;
      core_reset_n      <= 1'b0;
      vector_fetch      <= 1'b0;
      vector_addr       <= `VECTOR_LOW_ADDR;
      clock_source      <= 3'b000;
      oscillator_enable <= 1'b1;
    end else begin
      reset_pin_out     <= 1'b0; // RQ13
      reset_pin_oe      <= supply_filtered || ext_event || wdg_event ||
                           (state == ST_DELAY && width_count < OUT_WIDTH[15:0]); // RQ3 RQ6
      core_reset_n      <= ~(supply_filtered || ext_event || wdg_event) &&
                           (state == ST_RUN || release_event); // RQ19
      vector_fetch      <= (state == ST_STAB) && (count == STAB_CYCLES[15:0] - 16'h0001) ||
                           (state == ST_FETCH) && (count == 16'h0000);
      vector_addr       <= (state == ST_FETCH) ? `VECTOR_HIGH_ADDR : `VECTOR_LOW_ADDR; // RQ8
      clock_source      <= clock_source_select; // RQ15
      oscillator_enable <= 1'b1; // RQ16
    end
  end

  // --------------------------------------------------------------------------
  // APB access decode
  // --------------------------------------------------------------------------
  assign apb_write = psel && penable && pwrite;
  assign apb_read  = psel && penable && !pwrite;
  assign events    = {release_event, wdg_event, supply_event, ext_event};

  // --------------------------------------------------------------------------
  // Reset cause flags
  // --------------------------------------------------------------------------
  // Hardware set beats software clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_reset_flag   <= 1'b1;
      watchdog_reset_flag <= 1'b0;
    end else begin
      if (supply_event)
        supply_reset_flag <= 1'b1; // RQ4
      else if (apb_write && paddr == `RSM_FLAGS_OFFSET && !pwdata[`FLAG_SUPPLY_BIT])
        supply_reset_flag <= 1'b0; // RQ4 RQ17
      if (wdg_event)
        watchdog_reset_flag <= 1'b1; // RQ18
      else if (supply_event)
        watchdog_reset_flag <= 1'b0; // RQ18
      else if (apb_write && paddr == `RSM_FLAGS_OFFSET && !pwdata[`FLAG_WATCHDOG_BIT])
        watchdog_reset_flag <= 1'b0; // RQ18
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  // Write one to clear; a new event in the same cycle keeps its bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `EV_RESET;
      mask   <= `EV_RESET;
      irq    <= 1'b0;
    end else begin
      if (apb_write && paddr == `RSM_STATUS_OFFSET)
        status <= (status & ~pwdata[`EV_WIDTH-1:0]) | events;
      else
        status <= status | events;
      if (apb_write && paddr == `RSM_MASK_OFFSET)
        mask <= pwdata[`EV_WIDTH-1:0];
      irq <= |(status & mask);
    end
  end

  // --------------------------------------------------------------------------
  // APB answer: zero wait states, unmapped reads zero with error
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `RSM_STATUS_OFFSET: prdata <= {28'h0000000, status};
          `RSM_MASK_OFFSET:   prdata <= {28'h0000000, mask};
          `RSM_FLAGS_OFFSET:  prdata <= {27'h0000000, supply_reset_flag, 3'b000,
                                         watchdog_reset_flag};
          `RSM_CONFIG_OFFSET: prdata <= {24'h000000, state, clock_source_select,
                                         threshold_select, supply_filtered};
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

//--- core/reset_sequence_manager_map.vh
// Constants of the reset sequence manager: offsets, fields, resets and timing counts
`ifndef RESET_SEQUENCE_MANAGER_MAP_VH
`define RESET_SEQUENCE_MANAGER_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RSM_STATUS_OFFSET     12'h000
`define RSM_MASK_OFFSET       12'h004
`define RSM_FLAGS_OFFSET      12'h008
`define RSM_CONFIG_OFFSET     12'h00c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EV_EXTERNAL_BIT       0
`define EV_SUPPLY_BIT         1
`define EV_WATCHDOG_BIT       2
`define EV_RELEASE_BIT        3
`define EV_WIDTH              4
`define FLAG_WATCHDOG_BIT     0
`define FLAG_SUPPLY_BIT       4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define EV_RESET              4'h0
`define FLAGS_RESET           8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS         100
`define STAB_CYCLES           4096
`define FETCH_CYCLES          2
`define VECTOR_LOW_ADDR       16'hfffe
`define VECTOR_HIGH_ADDR      16'hffff
`define MIN_OUT_WIDTH_NS      20000
`define MIN_OUT_WIDTH_CYCLES  ((`MIN_OUT_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_IN_WIDTH_NS       300
`define MIN_IN_WIDTH_CYCLES   ((`MIN_IN_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUPPLY_GLITCH_NS      400
`define SUPPLY_GLITCH_CYCLES  ((`SUPPLY_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif
